// ### design/eeprom_write_ctrl.sv
/*
   Write-side command logic of a 3-wire serial EEPROM of 16-bit words, with the word
   array held in flip-flops.
   Assumes select, serial clock and serial input arrive asynchronously from a host and
   that the low-supply detector output is an asynchronous level.
*/
module eeprom_write_ctrl #(
   parameter int unsigned ADDR_W   = 6,                        // Word address width.
   parameter int unsigned PROG_CYC = eeprom_pkg::PROG_CYC      // Programming time in cycles.
) (
   input  wire logic core_clk_i,       // Core clock, 125 MHz.
   input  wire logic resetn_i,         // Asynchronous reset, active low.
   input  wire logic select_i,         // Device select pin.
   input  wire logic serial_clock_in_i,// Serial clock pin.
   input  wire logic serial_in_i,      // Serial data input pin.
   input  wire logic low_supply_i,     // Low-supply detector, high while tripped.
   output logic      serial_out_o,     // Serial output level.
   output logic      serial_out_oe_n_o,// Serial output enable, low while driving.
   output logic      prog_enabled_o,   // High in program-enable mode.
   output logic      busy_o            // High while the array is being programmed.
);
   localparam int unsigned LEN_SHORT = 1 + eeprom_pkg::OP_W + ADDR_W;
   localparam int unsigned LEN_DATA  = LEN_SHORT + eeprom_pkg::WORD_W;
   localparam int unsigned WORDS     = 1 << ADDR_W;

   // The shifter holds at most a 27-bit frame, so wider addresses cannot be served.
   if (ADDR_W < 2 || ADDR_W > 8) begin : g_bad_addr_w
      $error("ADDR_W must be 2..8");
   end
   if (PROG_CYC < 2) begin : g_bad_prog_cyc
      $error("PROG_CYC must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and glitch filters.
   logic [2:0] meta_q, sync_q, filt_q;
   logic [2:0][4:0] glitch_cnt_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
      end else begin
         meta_q <= {serial_in_i, serial_clock_in_i, select_i};
         sync_q <= meta_q;
      end
   end

   // A level must hold longer than the rejection width before it is taken.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         filt_q       <= 3'h0;
         glitch_cnt_q <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sync_q[i] == filt_q[i]) begin
               glitch_cnt_q[i] <= 5'h0;
            end else if (glitch_cnt_q[i] == 5'(eeprom_pkg::GLITCH_CYC - 1)) begin
               filt_q[i]       <= sync_q[i];
               glitch_cnt_q[i] <= 5'h0;
            end else begin
               glitch_cnt_q[i] <= glitch_cnt_q[i] + 5'h1;
            end
         end
      end
   end

   logic low_meta_q, low_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_meta_q <= 1'b1;
         low_q      <= 1'b1;
      end else begin
         low_meta_q <= low_supply_i;
         low_q      <= low_meta_q;
      end
   end

   logic sel, sck, sdi, sck_prev_q, sel_prev_q, sck_rise, sel_fall, sel_rise;
   assign sel = filt_q[0];
   assign sck = filt_q[1];
   assign sdi = filt_q[2];
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sck_prev_q <= 1'b0;
         sel_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck;
         sel_prev_q <= sel;
      end
   end
   assign sck_rise = sck & ~sck_prev_q;
   assign sel_fall = ~sel & sel_prev_q;
   assign sel_rise = sel & ~sel_prev_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Command shifter: counts clocks after the start bit, saturating at 63.
   logic        started_q;
   logic [5:0]  bit_cnt_q;
   logic [26:0] shift_q;
   logic        prog_busy;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         started_q <= 1'b0;
         bit_cnt_q <= 6'h0;
         shift_q   <= '0;
      end else if (!sel || prog_busy) begin
         started_q <= 1'b0;
         bit_cnt_q <= 6'h0;
      end else if (sck_rise) begin
         if (!started_q) begin
            if (sdi) begin
               started_q <= 1'b1;
               bit_cnt_q <= 6'h1;
            end
         end else begin
            shift_q <= {shift_q[25:0], sdi};
            if (bit_cnt_q != 6'h3F) bit_cnt_q <= bit_cnt_q + 6'h1;
         end
      end
   end

   // Field extraction depends on whether the data field was sent.
   logic [1:0]        op_s, op_l;
   logic [ADDR_W-1:0] addr_s, addr_l;
   logic [15:0]       data_l;
   assign op_s   = shift_q[ADDR_W+1:ADDR_W];
   assign addr_s = shift_q[ADDR_W-1:0];
   assign op_l   = shift_q[ADDR_W+17:ADDR_W+16];
   assign addr_l = shift_q[ADDR_W+15:16];
   assign data_l = shift_q[15:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Decode at select fall; exact length match only.
   eeprom_pkg::prog_state_e state_q;
   eeprom_pkg::prog_job_s job_q;
   logic                enable_q;
   logic                short_ok, long_ok, launch;
   logic [1:0]          ext_s, ext_l;
   assign short_ok  = started_q && bit_cnt_q == 6'(LEN_SHORT);
   assign long_ok   = started_q && bit_cnt_q == 6'(LEN_DATA);
   assign ext_s     = addr_s[ADDR_W-1:ADDR_W-2];
   assign ext_l     = addr_l[ADDR_W-1:ADDR_W-2];
   assign prog_busy = state_q == eeprom_pkg::ST_BUSY;

   eeprom_pkg::prog_cmd_e cmd_d;
   always_comb begin
      cmd_d = eeprom_pkg::CMD_NONE;
      if (short_ok && op_s == eeprom_pkg::OP_ERASE)
         cmd_d = eeprom_pkg::CMD_ERASE;
      else if (short_ok && op_s == eeprom_pkg::OP_EXT && ext_s == eeprom_pkg::EXT_ERASE_ALL)
         cmd_d = eeprom_pkg::CMD_ERASE_ALL;
      else if (long_ok && op_l == eeprom_pkg::OP_WRITE)
         cmd_d = eeprom_pkg::CMD_WRITE;
      else if (long_ok && op_l == eeprom_pkg::OP_EXT && ext_l == eeprom_pkg::EXT_FILL)
         cmd_d = eeprom_pkg::CMD_FILL;
   end
   assign launch = sel_fall && !prog_busy && enable_q && !low_q
                   && cmd_d != eeprom_pkg::CMD_NONE;

   // Program mode register; the supply lockout wins over any enable.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         enable_q <= 1'b0;
      end else if (low_q) begin
         enable_q <= 1'b0;
      end else if (sel_fall && short_ok && op_s == eeprom_pkg::OP_EXT) begin
         if (ext_s == eeprom_pkg::EXT_ENABLE) enable_q <= 1'b1;
         if (ext_s == eeprom_pkg::EXT_DISABLE) enable_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-entry job buffer between decoder and array writer.
   eeprom_pkg::prog_job_s buf_q [2];
   logic [1:0] buf_cnt_q;
   logic       buf_rd_q, buf_wr_q, in_valid, in_ready, out_valid, out_ready;
   assign in_valid  = launch;
   assign in_ready  = buf_cnt_q != 2'h2;
   assign out_valid = buf_cnt_q != 2'h0;
   assign out_ready = state_q == eeprom_pkg::ST_IDLE && !low_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         buf_cnt_q <= 2'h0;
         buf_rd_q  <= 1'b0;
         buf_wr_q  <= 1'b0;
         buf_q[0]  <= '0;
         buf_q[1]  <= '0;
      end else if (low_q) begin
         buf_cnt_q <= 2'h0;
         buf_rd_q  <= 1'b0;  // Pointers restart with the count, else a stale entry is read.
         buf_wr_q  <= 1'b0;
      end else begin
         if (in_valid && in_ready) begin
            buf_q[buf_wr_q].cmd  <= cmd_d;
            buf_q[buf_wr_q].addr <= 8'(long_ok ? addr_l : addr_s);
            buf_q[buf_wr_q].data <= data_l;
            buf_wr_q <= ~buf_wr_q;
         end
         if (out_valid && out_ready) buf_rd_q <= ~buf_rd_q;
         buf_cnt_q <= buf_cnt_q + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Array writer; memory changes only at the end of a full programming time.
   logic [15:0] mem_q [WORDS];
   logic [31:0] prog_cnt_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q    <= eeprom_pkg::ST_IDLE;
         prog_cnt_q <= 32'h0;
         job_q      <= '0;
      end else begin
         case (state_q)
            eeprom_pkg::ST_IDLE: if (out_valid && out_ready) begin
               job_q      <= buf_q[buf_rd_q];
               prog_cnt_q <= 32'(PROG_CYC - 1);
               state_q    <= eeprom_pkg::ST_BUSY;
            end
            eeprom_pkg::ST_BUSY: if (prog_cnt_q == 32'h0) state_q <= eeprom_pkg::ST_DONE;
                     else prog_cnt_q <= prog_cnt_q - 32'h1;
            eeprom_pkg::ST_DONE: state_q <= eeprom_pkg::ST_IDLE;
            default: state_q <= eeprom_pkg::ST_IDLE;
         endcase
      end
   end

   // Commit at the final busy cycle; a low supply there leaves data unspecified only in the part.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < WORDS; i++) mem_q[i] <= eeprom_pkg::ERASED_WORD;
      end else if (prog_busy && prog_cnt_q == 32'h0) begin
         for (int i = 0; i < WORDS; i++) begin
            case (job_q.cmd)
               eeprom_pkg::CMD_WRITE:     if (job_q.addr == 8'(i)) mem_q[i] <= job_q.data;
               eeprom_pkg::CMD_ERASE:     if (job_q.addr == 8'(i)) mem_q[i] <= eeprom_pkg::ERASED_WORD;
               eeprom_pkg::CMD_FILL:      mem_q[i] <= job_q.data;
               eeprom_pkg::CMD_ERASE_ALL: mem_q[i] <= eeprom_pkg::ERASED_WORD;
               default:                   mem_q[i] <= mem_q[i];
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial output: status shown only while selected after a launch.
   logic verify_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         verify_q          <= 1'b0;
         serial_out_o      <= 1'b1;
         serial_out_oe_n_o <= 1'b1;
         prog_enabled_o    <= 1'b0;
         busy_o            <= 1'b0;
      end else begin
         if (launch) verify_q <= 1'b1;
         else if (sel && started_q) verify_q <= 1'b0;  // A new start bit releases the pin.
         serial_out_o      <= !(prog_busy || out_valid);
         serial_out_oe_n_o <= !(sel && verify_q && !started_q);
         prog_enabled_o    <= enable_q;
         busy_o            <= prog_busy || out_valid;
      end
   end
   // sel_rise kept for readability of the select edge pair.
   logic unused_rise;
   assign unused_rise = sel_rise;
endmodule // eeprom_write_ctrl

// ### design/eeprom_pkg.sv
/*
   Package for the serial EEPROM write-control block: command codes, field widths,
   job and state types and timing counts.
   Assumes a 125 MHz core clock that samples the slow serial pins.
*/
package eeprom_pkg;
   localparam int unsigned CLK_PERIOD_PS   = 8000;          // Core clock period in ps.
   localparam int unsigned GLITCH_NS       = 20;            // Widest pulse the filter rejects.
   localparam int unsigned GLITCH_CYC      = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
   localparam int unsigned PROG_MS         = 8;             // Longest internal programming time.
   localparam int unsigned PROG_CYC        = (PROG_MS * 1000000) / (CLK_PERIOD_PS / 1000); // Kept in ns to stay in 32 bits.
   localparam int unsigned WORD_W          = 16;            // Data word width.
   localparam int unsigned OP_W            = 2;             // Opcode width after the start bit.
   localparam logic [15:0] ERASED_WORD     = 16'hFFFF;      // Value of an erased word.
   // Opcodes; the extended group uses opcode 00 and the top two address bits.
   localparam logic [1:0]  OP_EXT          = 2'h0;
   localparam logic [1:0]  OP_WRITE        = 2'h1;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [1:0]  OP_ERASE        = 2'h3;
   localparam logic [1:0]  EXT_DISABLE     = 2'h0;          // program_disable_cmd
   localparam logic [1:0]  EXT_FILL        = 2'h1;          // fill_all_words
   localparam logic [1:0]  EXT_ERASE_ALL   = 2'h2;          // erase_all_words
   localparam logic [1:0]  EXT_ENABLE      = 2'h3;          // program_enable_cmd

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0, CMD_WRITE = 3'h1, CMD_ERASE = 3'h2, CMD_FILL = 3'h3, CMD_ERASE_ALL = 3'h4
   } prog_cmd_e;

   // One programming job handed from the command decoder to the array writer.
   typedef struct packed {
      prog_cmd_e   cmd;
      logic [7:0]  addr;
      logic [15:0] data;
   } prog_job_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_BUSY = 3'b010, ST_DONE = 3'b100
   } prog_state_e;
endpackage

// ### sim/eeprom_write_ctrl_asserts.sv
/*
   Port checker for the EEPROM write-control block.
   Assumes it is bound to the top module and sees only its ports.
*/
module eeprom_write_ctrl_chk #(
   parameter int unsigned ADDR_W   = 6,  // Word address width.
   parameter int unsigned PROG_CYC = 50  // Programming time in cycles.
) (
   input wire logic core_clk_i,        // Core clock.
   input wire logic resetn_i,          // Reset, active low.
   input wire logic select_i,          // Device select.
   input wire logic serial_clock_in_i, // Serial clock.
   input wire logic serial_in_i,       // Serial data in.
   input wire logic low_supply_i,      // Low-supply detector.
   input wire logic serial_out_o,      // Serial output level.
   input wire logic serial_out_oe_n_o, // Output enable, low while driving.
   input wire logic prog_enabled_o,    // Program-enable mode.
   input wire logic busy_o             // Programming in progress.
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] busy_cnt_q;  // Length of the current busy stretch.
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // Count busy cycles so that the job length can be bounded without long repetitions.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) busy_cnt_q <= 32'h0;
      else busy_cnt_q <= busy_o ? busy_cnt_q + 32'h1 : 32'h0;
   end
   job_after_sel_a: assert property ($rose(busy_o) |-> !select_i && !$past(select_i, 2))
      else $error("job started while select high");
   job_enabled_a: assert property ($rose(busy_o) |-> $past(prog_enabled_o))
      else $error("job started in disable mode");
   job_length_a: assert property ($fell(busy_o) |-> busy_cnt_q >= PROG_CYC - 1 && busy_cnt_q <= PROG_CYC + 4)
      else $error("job length off");
   busy_cap_a: assert property (busy_cnt_q <= PROG_CYC + 8)
      else $error("job overran its time");
   mode_at_sel_a: assert property ($rose(prog_enabled_o) |-> !select_i && !$past(select_i, 2))
      else $error("mode changed with select high");
   supply_lock_a: assert property (low_supply_i [*5] |-> !prog_enabled_o)
      else $error("low supply left mode enabled");
   busy_shows_a: assert property (busy_o && $past(busy_o) && !serial_out_oe_n_o && !$past(serial_out_oe_n_o)
      |-> !serial_out_o)
      else $error("busy not shown low");
   ready_shows_a: assert property (!busy_o && !$past(busy_o) && !serial_out_oe_n_o && !$past(serial_out_oe_n_o)
      |-> serial_out_o)
      else $error("ready not shown high");
   idle_hiz_a: assert property (!select_i [*8] |-> serial_out_oe_n_o)
      else $error("output driven while deselected");
   mode_frozen_a: assert property (busy_o && $past(busy_o) && !$past(low_supply_i, 3) |-> $stable(prog_enabled_o))
      else $error("mode changed during programming");
   cov_job_c: cover property ($rose(busy_o));
   cov_enable_c: cover property ($rose(prog_enabled_o));
   cov_verify_c: cover property (busy_o && !serial_out_oe_n_o);
endmodule // eeprom_write_ctrl_chk

bind eeprom_write_ctrl eeprom_write_ctrl_chk #(.ADDR_W(ADDR_W), .PROG_CYC(PROG_CYC)) i_chk (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .select_i(select_i), .serial_clock_in_i(serial_clock_in_i),
   .serial_in_i(serial_in_i), .low_supply_i(low_supply_i), .serial_out_o(serial_out_o),
   .serial_out_oe_n_o(serial_out_oe_n_o), .prog_enabled_o(prog_enabled_o), .busy_o(busy_o));

// ### sim/eeprom_host_model.sv
/*
   Host model that frames commands on the serial pins.
   Assumes the core clock paces an 80 ns serial clock that rests low between frames.
*/
module eeprom_host_model (
   input  wire logic core_clk_i, // Core clock used for pacing.
   output logic      select_o,   // Device select.
   output logic      sclk_o,     // Serial clock.
   output logic      sdata_o     // Serial data.
);
   timeunit 1ns;
   timeprecision 100ps;
   // Select rests low so that an idle device never changes memory.
   initial begin
      select_o = 1'b0;
      sclk_o = 1'b0;
      sdata_o = 1'b0;
   end
   // Wait n core cycles, then step just past the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // Send n bits MSB first; gl picks a bit preceded by a 16 ns clock glitch.
   task automatic frame(input logic [31:0] bits, input int n, input int gl);
      select_o = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         sdata_o = bits[i];
         if (i == gl) begin
            tick(1);
            sclk_o = 1'b1;
            tick(2);
            sclk_o = 1'b0;
         end
         tick(5);
         sclk_o = 1'b1;
         tick(5);
         sclk_o = 1'b0;
      end
      tick(3);
      sdata_o = ~sdata_o; // The released line must not keep the last bit.
      select_o = 1'b0;
      tick(25);
   endtask
   // Raise or drop select alone, as a status poll does.
   task automatic sel(input logic v);
      tick(1);
      select_o = v;
   endtask
endmodule // eeprom_host_model

// ### sim/tb_eeprom_write_ctrl.sv
/*
   Self-checking bench for the EEPROM write-control block.
   Assumes the host model and the bound checker are compiled alongside.
*/
module tb_eeprom_write_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned PCYC = 50; // Short programming time keeps the run brief.
   logic clk = 1'b0;
   logic resetn, low_supply, sel, sclk, sdata, dout, dout_oe_n, prog_en, busy;
   logic [15:0] wdata = 16'hC3A5; // Data field of write and fill frames.
   int   err_total = 0;
   int   n_tests = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   eeprom_host_model i_host (.core_clk_i(clk), .select_o(sel), .sclk_o(sclk), .sdata_o(sdata));
   eeprom_write_ctrl #(.ADDR_W(6), .PROG_CYC(PCYC)) i_dut (
      .core_clk_i(clk), .resetn_i(resetn), .select_i(sel), .serial_clock_in_i(sclk),
      .serial_in_i(sdata), .low_supply_i(low_supply), .serial_out_o(dout),
      .serial_out_oe_n_o(dout_oe_n), .prog_enabled_o(prog_en), .busy_o(busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
         err_total++;
      end
   endtask
   // The array has no read port here, so stored words are looked at in place.
   task automatic chk_word(input string what, input int a, input logic [15:0] exp);
      n_tests++;
      if (i_dut.mem_q[a] !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, i_dut.mem_q[a]);
         err_total++;
      end
   endtask
   // Build a command; write and fill carry data, xtra adds or drops trailing clocks.
   task automatic send(input logic [1:0] op, input logic [5:0] a, input int xtra, input int dum, input int gl);
      logic [31:0] b;
      int          n;
      n = (op == eeprom_pkg::OP_WRITE || (op == eeprom_pkg::OP_EXT && a[5:4] == eeprom_pkg::EXT_FILL)) ? 25 : 9;
      b = (n == 25) ? {7'h0, 1'b1, op, a, wdata} : {23'h0, 1'b1, op, a};
      b = (xtra < 0) ? b >> 1 : b << xtra;
      i_host.frame(b, n + xtra + dum, gl);
   endtask
   // Look for a job start, then wait a bounded time for it to end.
   task automatic expect_job(input string what, input logic exp);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 120 && seen !== 1'b1; i++) begin
         i_host.tick(1);
         seen = busy;
      end
      chk(what, exp, seen);
      for (int i = 0; i < 300 && busy !== 1'b0; i++) i_host.tick(1);
      if (busy !== 1'b0) begin
         chk("busy end", 1'b0, busy);
         close_out();
      end
   endtask
   task automatic job(input string what, input logic [1:0] op, input logic [5:0] a, input int xtra,
                      input int gl, input logic exp);
      send(op, a, xtra, 0, gl);
      expect_job(what, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("prog_en", 1'b0, prog_en);
      chk("busy", 1'b0, busy);
      chk("dout_oe_n", 1'b1, dout_oe_n);
   endtask
   // Disable first as a careful host does, then enable, then a disable one clock too long.
   task automatic t_mode();
      send(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_DISABLE, 4'h0}, 0, 0, -1);
      send(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_ENABLE, 4'h5}, 0, 0, -1);
      chk("prog_en", 1'b1, prog_en);
      send(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_DISABLE, 4'h0}, 1, 0, -1);
      chk("prog_en", 1'b1, prog_en);
   endtask
   // Write behind two dummy clocks, then poll the status while it programs.
   task automatic t_write();
      send(eeprom_pkg::OP_WRITE, 6'h2A, 0, 2, -1);
      i_host.sel(1'b1);
      i_host.tick(10);
      chk("busy", 1'b1, busy);
      chk("dout_oe_n", 1'b0, dout_oe_n);
      chk("dout busy", 1'b0, dout);
      expect_job("write", 1'b1);
      i_host.tick(4);
      chk("dout ready", 1'b1, dout);
      i_host.sel(1'b0);
      i_host.tick(25);
      chk_word("written word", 6'h2A, 16'hC3A5);
      chk_word("neighbour word", 6'h2B, 16'hFFFF);
   endtask
   task automatic t_cancel();
      job("long write", eeprom_pkg::OP_WRITE, 6'h01, 1, -1, 1'b0);
      chk_word("long write word", 6'h01, 16'hFFFF);
      job("short erase", eeprom_pkg::OP_ERASE, 6'h01, -1, -1, 1'b0);
      job("long fill", eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_FILL, 4'h3}, 1, -1, 1'b0);
      chk_word("long fill word", 6'h00, 16'hFFFF);
   endtask
   // Fill first, so that erases and overwrites change words that are not yet all ones.
   task automatic t_kinds();
      job("fill", eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_FILL, 4'hE}, 0, -1, 1'b1);
      chk_word("fill word", 6'h00, 16'hC3A5);
      job("erase", eeprom_pkg::OP_ERASE, 6'h3F, 0, -1, 1'b1);
      chk_word("erased word", 6'h3F, 16'hFFFF);
      chk_word("kept word", 6'h3E, 16'hC3A5);
      wdata = 16'h5A0F;
      job("overwrite", eeprom_pkg::OP_WRITE, 6'h3E, 0, -1, 1'b1);
      chk_word("overwritten word", 6'h3E, 16'h5A0F);
      job("glitch erase", eeprom_pkg::OP_ERASE, 6'h07, 0, 4, 1'b1);
      chk_word("glitch erase word", 6'h07, 16'hFFFF);
      job("erase all", eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_ERASE_ALL, 4'h9}, 0, -1, 1'b1);
      chk_word("erase all word", 6'h3E, 16'hFFFF);
   endtask
   task automatic t_disable();
      send(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_DISABLE, 4'h0}, 0, 0, -1);
      chk("prog_en", 1'b0, prog_en);
      job("blocked write", eeprom_pkg::OP_WRITE, 6'h10, 0, -1, 1'b0);
      chk_word("blocked word", 6'h10, 16'hFFFF);
   endtask
   // A supply dip must leave the mode disabled until the host enables again.
   task automatic t_supply();
      send(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_ENABLE, 4'h0}, 0, 0, -1);
      low_supply = 1'b1;
      i_host.tick(10);
      chk("prog_en", 1'b0, prog_en);
      low_supply = 1'b0;
      i_host.tick(10);
      job("locked erase", eeprom_pkg::OP_ERASE, 6'h05, 0, -1, 1'b0);
      send(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_ENABLE, 4'h0}, 0, 0, -1);
      job("erase again", eeprom_pkg::OP_ERASE, 6'h05, 0, -1, 1'b1);
   endtask
   // Reset for 20 cycles, then run every scenario in turn.
   initial begin
      resetn = 1'b0;
      low_supply = 1'b0;
      i_host.tick(20);
      resetn = 1'b1;
      i_host.tick(10);
      t_reset();
      t_mode();
      t_write();
      t_cancel();
      t_kinds();
      t_disable();
      t_supply();
      close_out();
   end
endmodule // tb_eeprom_write_ctrl
